// ==== rtl/cr_pkg.sv ====
// Shared constants for the clock recovery watchdog block
package cr_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] FREQ_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] MASK_OFS   = 8'h0c;
  localparam logic [7:0] COUNT_OFS  = 8'h10;
  localparam logic [7:0] RESULT_OFS = 8'h14;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int CTRL_RUN_BIT     = 0;
  localparam int CTRL_UNIT_BIT    = 1;
  localparam int CTRL_RST_EXP_BIT = 2;
  localparam int CTRL_RST_RET_BIT = 3;
  localparam int CTRL_PROG_BIT    = 4;
  localparam int CTRL_SOFT_BIT    = 5;
  localparam int CTRL_COUNT_LSB   = 8;
  localparam int FREQ_N_LSB       = 0;
  localparam int FREQ_M_LSB       = 8;
  localparam int FREQ_SEL_LSB     = 16;
  localparam int ST_EXPIRY_BIT    = 0;
  localparam int ST_RETUNE_BIT    = 1;
  localparam int COUNT_ARMED_BIT  = 8;
  localparam int COUNT_W          = 5;
  localparam int N_W              = 8;
  localparam int M_W              = 7;
  localparam int SEL_W            = 5;
  localparam int GEAR_W           = 24;
  localparam int PROD_W           = 33;
  localparam int DIV_W            = 8;
  localparam int ST_W             = 2;

  // ----------------------------------------------------------------
  // Writable bits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_WMASK  = 32'h0000_1f3f;
  localparam logic [31:0] FREQ_WMASK  = 32'h001f_7fff;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_1000;
  localparam logic [31:0] FREQ_RESET  = 32'h0000_0000;
  localparam logic [1:0]  MASK_RESET  = 2'h0;
  localparam logic [8:0]  RATIO_BIAS  = 9'h003;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_KHZ           = 125000;
  localparam int unsigned TICK_SHORT_MS     = 150;
  localparam int unsigned TICK_LONG_MS      = 2500;
  localparam int unsigned TICK_SHORT_CYCLES = CLK_KHZ * TICK_SHORT_MS;
  localparam int unsigned TICK_LONG_CYCLES  = CLK_KHZ * TICK_LONG_MS;
  localparam logic [4:0]  RESET_PULSE_CYCLES = 5'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} div_state_type;

endpackage

// ==== rtl/tick_gen.sv ====
// Unit tick generator for the watchdog countdown
`timescale 1ns/1ns
module tick_gen #(
  parameter int unsigned SHORT_CYCLES = cr_pkg::TICK_SHORT_CYCLES,
  parameter int unsigned LONG_CYCLES  = cr_pkg::TICK_LONG_CYCLES
)(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Control
  input  wire logic restart,
  input  wire logic long_unit,
  // Tick out
  output logic      tick
);
  logic [31:0] cnt_q;
  logic [31:0] limit;

  assign limit = long_unit ? 32'(LONG_CYCLES - 1) : 32'(SHORT_CYCLES - 1);

  // ----------------------------------------------------------------
  // Cycle counter, one tick per unit
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= 32'h0;
    else if (restart || cnt_q >= limit)
      cnt_q <= 32'h0;
    else
      cnt_q <= cnt_q + 32'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tick <= 1'b0;
    else
      tick <= !restart && (cnt_q == limit);
  end
endmodule

// ==== rtl/ratio_divider.sv ====
// Sequential restoring divider for the clock ratio
`timescale 1ns/1ns
module ratio_divider (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rstn,
  // Request
  input  wire logic                      start,
  input  wire logic [cr_pkg::PROD_W-1:0] dividend,
  input  wire logic [cr_pkg::DIV_W-1:0]  divisor,
  // Answer
  output logic                           busy,
  output logic                           done,
  output logic [cr_pkg::PROD_W-1:0]      quotient
);
  cr_pkg::div_state_type          state_q;
  logic [cr_pkg::DIV_W-1:0]       rem_q;
  logic [cr_pkg::DIV_W-1:0]       div_q;
  logic [5:0]                     bits_q;
  logic [cr_pkg::DIV_W:0]         trial;

  assign trial = {rem_q, quotient[cr_pkg::PROD_W-1]};
  assign busy  = (state_q == cr_pkg::DIV_RUN);

  // ----------------------------------------------------------------
  // One quotient bit per cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q  <= cr_pkg::DIV_IDLE;
      rem_q    <= '0;
      div_q    <= '0;
      bits_q   <= 6'h0;
      quotient <= '0;
      done     <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      case (state_q)
        cr_pkg::DIV_IDLE:
          if (start)
          begin
            quotient <= dividend;
            div_q    <= divisor;
            rem_q    <= '0;
            bits_q   <= 6'(cr_pkg::PROD_W);
            state_q  <= cr_pkg::DIV_RUN;
          end
        cr_pkg::DIV_RUN:
        begin
          if (trial >= {1'b0, div_q})
          begin
            rem_q    <= cr_pkg::DIV_W'(trial - {1'b0, div_q});
            quotient <= {quotient[cr_pkg::PROD_W-2:0], 1'b1};
          end
          else
          begin
            rem_q    <= trial[cr_pkg::DIV_W-1:0];
            quotient <= {quotient[cr_pkg::PROD_W-2:0], 1'b0};
          end
          bits_q <= bits_q - 6'h1;
          if (bits_q == 6'h1)
          begin
            state_q <= cr_pkg::DIV_IDLE;
            done    <= 1'b1;
          end
        end
        default:
          state_q <= cr_pkg::DIV_IDLE;
      endcase
    end
  end
endmodule

// ==== rtl/clock_recovery_watchdog.sv ====
// Recovery watchdog, retune reset and CPU clock ratio control behind Wishbone
//
// Register access over Wishbone and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// Operation
// - Expiry flag reads 0 before expiry, 1 after; writing 1 clears, 0 keeps.
// - Expiry interval is held in a 5-bit reload field.
// - Unit select 0 gives 150 ms ticks, 1 gives 2.5 s ticks.
// - Countdown reaching zero sets the sticky expiry flag until software clears it.
// - Reset pulse on every expiry only while reset-on-expiry enable is 1.
// - Reset pulse after each frequency change only while reset-on-retune enable is 1.
// - In programmable mode CPU clock is gear times (N+3) over (M+3).
// - Gear comes from latched strap select or software select, whichever is used.
// - Run enable 0 stops and reloads; 1 counts after a frequency change.
module clock_recovery_watchdog #(
  parameter int unsigned SHORT_TICK_CYCLES = cr_pkg::TICK_SHORT_CYCLES,
  parameter int unsigned LONG_TICK_CYCLES  = cr_pkg::TICK_LONG_CYCLES
)(
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           rstn,
  // Wishbone slave
  input  wire logic                           wb_cyc_i,
  input  wire logic                           wb_stb_i,
  input  wire logic                           wb_we_i,
  input  wire logic [7:0]                     wb_adr_i,
  input  wire logic [3:0]                     wb_sel_i,
  input  wire logic [31:0]                    wb_dat_i,
  output logic [31:0]                         wb_dat_o,
  output logic                                wb_ack_o,
  // Frequency select and gear table
  input  wire logic [cr_pkg::SEL_W-1:0]       strap_frequency_select,
  output logic [cr_pkg::SEL_W-1:0]            gear_index_o,
  input  wire logic [cr_pkg::GEAR_W-1:0]      gear_value_i,
  // Results
  output logic [cr_pkg::PROD_W-1:0]           cpu_freq_o,
  output logic                                sys_reset_o,
  output logic                                irq_o
);
  logic [31:0]                  ctrl_q;
  logic [31:0]                  freq_q;
  logic [31:0]                  ctrl_d;
  logic [31:0]                  freq_d;
  logic [cr_pkg::ST_W-1:0]      status_q;
  logic [cr_pkg::ST_W-1:0]      status_clr;
  logic [cr_pkg::ST_W-1:0]      status_set;
  logic [cr_pkg::ST_W-1:0]      mask_q;
  logic                         req;
  logic                         wr_take;
  logic [31:0]                  rd_word;
  logic                         watchdog_run_enable;
  logic                         tick_unit_select;
  logic                         reset_on_expiry_enable;
  logic                         reset_on_retune_enable;
  logic                         prog_freq_enable;
  logic                         soft_select_use;
  logic [cr_pkg::COUNT_W-1:0]   expiry_count_field;
  logic [cr_pkg::N_W-1:0]       num_val;
  logic [cr_pkg::M_W-1:0]       den_val;
  logic [cr_pkg::SEL_W-1:0]     soft_sel;
  logic [cr_pkg::SEL_W-1:0]     strap_meta_q;
  logic [cr_pkg::SEL_W-1:0]     strap_sync_q;
  logic [cr_pkg::SEL_W-1:0]     strap_latched_q;
  logic [1:0]                   strap_wait_q;
  logic                         retune_req;
  logic                         pending_q;
  logic                         div_start;
  logic                         div_busy;
  logic                         div_done;
  logic [cr_pkg::PROD_W-1:0]    div_quot;
  logic [cr_pkg::PROD_W-1:0]    ratio_q;
  logic [cr_pkg::COUNT_W-1:0]   count_q;
  logic                         armed_q;
  logic                         tick;
  logic                         expire;
  logic                         pulse_trigger;
  logic [4:0]                   pulse_cnt_q;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic reg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        r[8*i +: 8] = new_v[8*i +: 8];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Field views
  // ----------------------------------------------------------------
  assign watchdog_run_enable    = ctrl_q[cr_pkg::CTRL_RUN_BIT];
  assign tick_unit_select       = ctrl_q[cr_pkg::CTRL_UNIT_BIT];
  assign reset_on_expiry_enable = ctrl_q[cr_pkg::CTRL_RST_EXP_BIT];
  assign reset_on_retune_enable = ctrl_q[cr_pkg::CTRL_RST_RET_BIT];
  assign prog_freq_enable       = ctrl_q[cr_pkg::CTRL_PROG_BIT];
  assign soft_select_use        = ctrl_q[cr_pkg::CTRL_SOFT_BIT];
  assign expiry_count_field     = ctrl_q[cr_pkg::CTRL_COUNT_LSB +: cr_pkg::COUNT_W];
  assign num_val                = freq_q[cr_pkg::FREQ_N_LSB +: cr_pkg::N_W];
  assign den_val                = freq_q[cr_pkg::FREQ_M_LSB +: cr_pkg::M_W];
  assign soft_sel               = freq_q[cr_pkg::FREQ_SEL_LSB +: cr_pkg::SEL_W];

  // ----------------------------------------------------------------
  // Bus handshake and read data
  // ----------------------------------------------------------------
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_take = req & wb_we_i & wb_ack_o;
  assign ctrl_d  = merge_bytes(ctrl_q, wb_dat_i, wb_sel_i) & cr_pkg::CTRL_WMASK;
  assign freq_d  = merge_bytes(freq_q, wb_dat_i, wb_sel_i) & cr_pkg::FREQ_WMASK;

  always_comb
  begin
    rd_word = 32'h0;
    if (reg_hit(wb_adr_i, cr_pkg::CTRL_OFS))
      rd_word = ctrl_q;
    else if (reg_hit(wb_adr_i, cr_pkg::FREQ_OFS))
      rd_word = freq_q;
    else if (reg_hit(wb_adr_i, cr_pkg::STATUS_OFS))
      rd_word = {30'h0, status_q};
    else if (reg_hit(wb_adr_i, cr_pkg::MASK_OFS))
      rd_word = {30'h0, mask_q};
    else if (reg_hit(wb_adr_i, cr_pkg::COUNT_OFS))
      rd_word = {23'h0, armed_q, 3'h0, count_q};
    else if (reg_hit(wb_adr_i, cr_pkg::RESULT_OFS))
      rd_word = cpu_freq_o[31:0];
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= req & ~wb_ack_o;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wb_dat_o <= 32'h0;
    else if (req & ~wb_ack_o & ~wb_we_i)
      wb_dat_o <= rd_word;
  end

  // ----------------------------------------------------------------
  // Control, frequency and mask registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_q <= cr_pkg::CTRL_RESET;
    else if (wr_take && reg_hit(wb_adr_i, cr_pkg::CTRL_OFS))
      ctrl_q <= ctrl_d;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      freq_q <= cr_pkg::FREQ_RESET;
    else if (wr_take && reg_hit(wb_adr_i, cr_pkg::FREQ_OFS))
      freq_q <= freq_d;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      mask_q <= cr_pkg::MASK_RESET;
    else if (wr_take && reg_hit(wb_adr_i, cr_pkg::MASK_OFS) && wb_sel_i[0])
      mask_q <= wb_dat_i[cr_pkg::ST_W-1:0];
  end

  // ----------------------------------------------------------------
  // Sticky status, write one to clear, set wins
  // ----------------------------------------------------------------
  assign status_set = {div_done, expire};
  assign status_clr = (wr_take && reg_hit(wb_adr_i, cr_pkg::STATUS_OFS) && wb_sel_i[0]) ?
                      wb_dat_i[cr_pkg::ST_W-1:0] : '0;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      status_q <= '0;
    else
      status_q <= (status_q & ~status_clr) | status_set;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_o <= 1'b0;
    else
      irq_o <= |(status_q & mask_q);
  end

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_meta_q <= '0;
      strap_sync_q <= '0;
    end
    else
    begin
      strap_meta_q <= strap_frequency_select;
      strap_sync_q <= strap_meta_q;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      strap_wait_q    <= 2'h0;
      strap_latched_q <= '0;
    end
    else if (strap_wait_q != 2'h3)
    begin
      strap_wait_q <= strap_wait_q + 2'h1;
      if (strap_wait_q == 2'h2)
        strap_latched_q <= strap_sync_q;
    end
  end

  assign gear_index_o = soft_select_use ? soft_sel : strap_latched_q;

  // ----------------------------------------------------------------
  // Frequency change detection and ratio computation
  // ----------------------------------------------------------------
  assign retune_req = wr_take &&
                      ((reg_hit(wb_adr_i, cr_pkg::FREQ_OFS) && (|wb_sel_i[2:0])) ||
                       (reg_hit(wb_adr_i, cr_pkg::CTRL_OFS) &&
                        (ctrl_d[cr_pkg::CTRL_PROG_BIT] != prog_freq_enable ||
                         ctrl_d[cr_pkg::CTRL_SOFT_BIT] != soft_select_use)));
  assign div_start  = pending_q & ~div_busy;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pending_q <= 1'b0;
    else if (retune_req)
      pending_q <= 1'b1;
    else if (div_start)
      pending_q <= 1'b0;
  end

  // Divisor is M+3, never zero; a ratio above one is left to software
  ratio_divider u_div (
    .clk      (clk),
    .rstn     (rstn),
    .start    (div_start),
    .dividend (cr_pkg::PROD_W'(gear_value_i) * cr_pkg::PROD_W'({1'b0, num_val} + cr_pkg::RATIO_BIAS)),
    .divisor  (cr_pkg::DIV_W'({2'b0, den_val} + cr_pkg::RATIO_BIAS)),
    .busy     (div_busy),
    .done     (div_done),
    .quotient (div_quot)
  );

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ratio_q <= '0;
    else if (div_done)
      ratio_q <= div_quot;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cpu_freq_o <= '0;
    else
      cpu_freq_o <= prog_freq_enable ? ratio_q : cr_pkg::PROD_W'(gear_value_i);
  end

  // ----------------------------------------------------------------
  // Watchdog countdown
  // ----------------------------------------------------------------
  tick_gen #(
    .SHORT_CYCLES (SHORT_TICK_CYCLES),
    .LONG_CYCLES  (LONG_TICK_CYCLES)
  ) u_tick (
    .clk       (clk),
    .rstn      (rstn),
    .restart   (~armed_q | div_done),
    .long_unit (tick_unit_select),
    .tick      (tick)
  );

  assign expire = watchdog_run_enable & armed_q & tick & (count_q <= 5'h01);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count_q <= '0;
      armed_q <= 1'b0;
    end
    else if (!watchdog_run_enable)
    begin
      count_q <= expiry_count_field;
      armed_q <= 1'b0;
    end
    else if (div_done)
    begin
      count_q <= expiry_count_field;
      armed_q <= 1'b1;
    end
    else if (armed_q && tick)
    begin
      if (count_q <= 5'h01)
      begin
        count_q <= '0;
        armed_q <= 1'b0;
      end
      else
        count_q <= count_q - 5'h01;
    end
  end

  // ----------------------------------------------------------------
  // System reset pulse
  // ----------------------------------------------------------------
  assign pulse_trigger = (expire & reset_on_expiry_enable) |
                         (div_done & reset_on_retune_enable);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      pulse_cnt_q <= 5'h0;
    else if (pulse_trigger)
      pulse_cnt_q <= cr_pkg::RESET_PULSE_CYCLES;
    else if (pulse_cnt_q != 5'h0)
      pulse_cnt_q <= pulse_cnt_q - 5'h1;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      sys_reset_o <= 1'b0;
    else
      sys_reset_o <= pulse_trigger | (pulse_cnt_q > 5'h1);
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  flag_set_a: assert property (@(posedge clk) disable iff (!rstn)
    expire |=> status_q[cr_pkg::ST_EXPIRY_BIT]) else $error("expiry did not set flag");
  flag_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (status_clr[cr_pkg::ST_EXPIRY_BIT] && !expire) |=> !status_q[cr_pkg::ST_EXPIRY_BIT])
    else $error("write one did not clear flag");
  flag_keep_a: assert property (@(posedge clk) disable iff (!rstn)
    (status_q[cr_pkg::ST_EXPIRY_BIT] && !status_clr[cr_pkg::ST_EXPIRY_BIT]) |=> status_q[cr_pkg::ST_EXPIRY_BIT])
    else $error("flag lost without clear");
  expiry_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    (expire && reset_on_expiry_enable) |=> sys_reset_o) else $error("no reset on expiry");
  retune_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    (div_done && reset_on_retune_enable) |=> sys_reset_o) else $error("no reset on retune");
  pulse_cause_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sys_reset_o) |-> $past(pulse_trigger)) else $error("reset pulse without cause");
  pulse_width_a: assert property (@(posedge clk) disable iff (!rstn)
    $fell(sys_reset_o) |-> ($past(pulse_cnt_q) == 5'h1 && !$past(pulse_trigger))) else $error("reset pulse width");
  pulse_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sys_reset_o) |-> sys_reset_o [*8]) else $error("reset pulse too short");
  stop_reload_a: assert property (@(posedge clk) disable iff (!rstn)
    !watchdog_run_enable |=> (count_q == $past(expiry_count_field) && !armed_q)) else $error("stop did not reload");
  count_step_a: assert property (@(posedge clk) disable iff (!rstn)
    (watchdog_run_enable && armed_q && tick && !div_done && count_q > 5'h01) |=> count_q == $past(count_q) - 5'h01)
    else $error("countdown step wrong");
  gear_pick_a: assert property (@(posedge clk) disable iff (!rstn)
    soft_select_use |-> gear_index_o == soft_sel) else $error("gear select not software");
  ratio_out_a: assert property (@(posedge clk) disable iff (!rstn)
    (prog_freq_enable && $stable(prog_freq_enable) && $past(div_done)) |=> cpu_freq_o == $past(div_quot, 2))
    else $error("cpu clock ratio not applied");
endmodule

// ==== test/gear_model.sv ====
// Gear constant table model standing outside the watchdog block
`timescale 1ns/1ns
module gear_model (
  // Table lookup
  input  wire logic [4:0]  gear_index,
  output logic      [23:0] gear_value
);
  // Gear value grows with the index so that each selection is distinct
  assign gear_value = 24'h000100 + {19'h0, gear_index} * 24'h000010;
endmodule

// ==== test/tb_clock_recovery_watchdog.sv ====
// Register level testbench for the clock recovery watchdog
`timescale 1ns/1ns
module tb_clock_recovery_watchdog;
  logic        clk, rstn, cyc, stb, we, ack, sys_reset_o, irq_o, last;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, wb_dat_o;
  logic [4:0]  strap, gear_index_o;
  logic [23:0] gear_value;
  logic [32:0] cpu_freq_o;
  int          fail_count, compares, pulse_cnt, hi_cnt;

  clock_recovery_watchdog #(.SHORT_TICK_CYCLES(20), .LONG_TICK_CYCLES(50)) clock_recovery_watchdog_i (
    .clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(ack), .strap_frequency_select(strap),
    .gear_index_o(gear_index_o), .gear_value_i(gear_value), .cpu_freq_o(cpu_freq_o),
    .sys_reset_o(sys_reset_o), .irq_o(irq_o));
  gear_model gear_model_i (.gear_index(gear_index_o), .gear_value(gear_value));

  // ----------------------------------------------------------------
  // Bus access and comparison
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    // Request holds until the edge that samples ack high; data is taken there
    do @(posedge clk); while (ack !== 1'b1);
    q = wb_dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk({1'b0, q}, {1'b0, e});
  endtask
  task automatic wait_retune;
    logic [31:0] q;
    int n;
    n = 0;
    do begin wb(1'b0, cr_pkg::STATUS_OFS, 32'h0, q); n++; end while (q[1] !== 1'b1 && n < 40);
    if (q[1] !== 1'b1)
      fail_count++;
    @(negedge clk);
  endtask
  function automatic logic [32:0] ratio(input int idx, input int n, input int m);
    return 33'((256 + 16 * idx) * (n + 3) / (m + 3));
  endfunction
  task automatic test_done;
    if (fail_count == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Reset pulse monitor
  always @(negedge clk)
  begin
    if (sys_reset_o === 1'b1) hi_cnt++;
    if (sys_reset_o === 1'b1 && last !== 1'b1) pulse_cnt++;
    last = sys_reset_o;
  end

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    #(8 * 6000);
    fail_count++;
    test_done();
  end

  initial
  begin
    rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0; dat = 32'h0; strap = 5'h03;
    fail_count = 0; compares = 0; pulse_cnt = 0; hi_cnt = 0; last = 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(cr_pkg::CTRL_OFS, 32'h0000_1000);
    rd_chk(cr_pkg::STATUS_OFS, 32'h0000_0000);
    wr(8'h20, 32'hffff_ffff);
    rd_chk(8'h20, 32'h0000_0000);
    chk({28'h0, gear_index_o}, 33'h3);
    wr(cr_pkg::FREQ_OFS, 32'h0000_5d61);
    wait_retune();
    wr(cr_pkg::STATUS_OFS, 32'h0000_0003);
    pulse_cnt = 0; hi_cnt = 0;
    wr(cr_pkg::CTRL_OFS, 32'h0000_0219);
    wait_retune();
    chk(cpu_freq_o, ratio(3, 97, 93));
    rd_chk(cr_pkg::RESULT_OFS, 32'(ratio(3, 97, 93)));
    rd_chk(cr_pkg::STATUS_OFS, 32'h0000_0002);
    chk(33'(pulse_cnt), 33'h1);
    repeat (20) @(posedge clk);
    chk(33'(hi_cnt), 33'h10);
    rd_chk(cr_pkg::STATUS_OFS, 32'h0000_0002);
    repeat (15) @(posedge clk);
    rd_chk(cr_pkg::STATUS_OFS, 32'h0000_0003);
    chk(33'(pulse_cnt), 33'h1);
    wr(cr_pkg::STATUS_OFS, 32'h0000_0000);
    rd_chk(cr_pkg::STATUS_OFS, 32'h0000_0003);
    wr(cr_pkg::MASK_OFS, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk({32'h0, irq_o}, 33'h1);
    wr(cr_pkg::STATUS_OFS, 32'h0000_0001);
    rd_chk(cr_pkg::STATUS_OFS, 32'h0000_0002);
    @(negedge clk);
    chk({32'h0, irq_o}, 33'h0);
    wr(cr_pkg::CTRL_OFS, 32'h0000_0218);
    rd_chk(cr_pkg::COUNT_OFS, 32'h0000_0002);
    wr(cr_pkg::STATUS_OFS, 32'h0000_0003);
    pulse_cnt = 0; hi_cnt = 0;
    wr(cr_pkg::CTRL_OFS, 32'h0000_0137);
    wait_retune();
    chk({28'h0, gear_index_o}, 33'h0);
    chk(cpu_freq_o, ratio(0, 97, 93));
    chk(33'(pulse_cnt), 33'h0);
    repeat (30) @(posedge clk);
    rd_chk(cr_pkg::STATUS_OFS, 32'h0000_0002);
    repeat (40) @(posedge clk);
    rd_chk(cr_pkg::STATUS_OFS, 32'h0000_0003);
    chk(33'(pulse_cnt), 33'h1);
    chk(33'(hi_cnt), 33'h10);
    test_done();
  end
endmodule
